// file: rtl/thl_pkg.sv
// shared constants, codes and helpers for the hardware-limit timer
package thl_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] ADDR_CONTROL      = 8'h04;
	localparam logic [7:0] ADDR_LIMIT        = 8'h08;
	localparam logic [7:0] ADDR_PERIOD       = 8'h0C;
	localparam logic [7:0] ADDR_PULSE_WIDTH  = 8'h10;
	localparam logic [7:0] ADDR_COUNT        = 8'h14;
	localparam logic [7:0] ADDR_STATUS       = 8'h18;

	localparam logic [3:0] RESET_CLOCK_SELECT = 4'h0;
	localparam logic [7:0] RESET_CONTROL      = 8'h00;
	localparam logic [7:0] RESET_LIMIT        = 8'h00;
	localparam logic [7:0] RESET_PERIOD       = 8'hFF;
	localparam logic [7:0] RESET_PULSE_WIDTH  = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_ON_BIT        = 7;
	localparam int CTRL_PRESCALE_LSB  = 4;
	localparam int CTRL_POSTSCALE_LSB = 0;
	localparam int LIMIT_SYNC_BIT     = 7;
	localparam int LIMIT_MODE_LSB     = 0;
	localparam int STATUS_FLAG_BIT    = 0;

	// ****************************************
	// operating modes
	// ****************************************
	localparam logic [4:0] MODE_EDGE_LIMIT_RISE = 5'h0C;
	localparam logic [4:0] MODE_EDGE_LIMIT_FALL = 5'h0D;
	localparam logic [4:0] MODE_LVLRST_LOW      = 5'h0E;
	localparam logic [4:0] MODE_LVLRST_HIGH     = 5'h0F;
	localparam logic [4:0] MODE_MONO_RISE       = 5'h11;
	localparam logic [4:0] MODE_MONO_FALL       = 5'h12;
	localparam logic [4:0] MODE_MONO_BOTH       = 5'h13;
	localparam logic [4:0] MODE_LVLTRIG_LOW     = 5'h16;
	localparam logic [4:0] MODE_LVLTRIG_HIGH    = 5'h17;

	// ****************************************
	// clock source codes
	// ****************************************
	localparam logic [3:0] CS_PIN      = 4'h0;
	localparam logic [3:0] CS_FOSC4    = 4'h1;
	localparam logic [3:0] CS_FOSC     = 4'h2;
	localparam logic [3:0] CS_FAST     = 4'h3;
	localparam logic [3:0] CS_SLOW     = 4'h4;
	localparam logic [3:0] CS_MED_500K = 4'h5;
	localparam logic [3:0] CS_MED_31K  = 4'h6;
	localparam logic [3:0] CS_RSVD_LO  = 4'h7;
	localparam logic [3:0] CS_LOGIC_LO = 4'h8;
	localparam logic [3:0] CS_LOGIC_HI = 4'hE;
	localparam logic [3:0] CS_TO_INDEX = 4'h3;

	// ****************************************
	// counts
	// ****************************************
	localparam logic [1:0] RESTART_TICKS = 2'h2;
	localparam logic [1:0] FOSC4_LAST    = 2'h3;
	localparam int         SYNC_SOURCES  = 12;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} thl_state_e;
	typedef enum logic [2:0] {
		CL_OTHER, CL_EDGE_LIMIT, CL_LVLRST, CL_MONO, CL_LVLTRIG
	} thl_class_e;

	function automatic thl_class_e mode_class(input logic [4:0] m);
		if (m == MODE_EDGE_LIMIT_RISE || m == MODE_EDGE_LIMIT_FALL)
			return CL_EDGE_LIMIT;
		else if (m == MODE_LVLRST_LOW || m == MODE_LVLRST_HIGH)
			return CL_LVLRST;
		else if (m >= MODE_MONO_RISE && m <= MODE_MONO_BOTH)
			return CL_MONO;
		else if (m == MODE_LVLTRIG_LOW || m == MODE_LVLTRIG_HIGH)
			return CL_LVLTRIG;
		else
			return CL_OTHER;
	endfunction

	// selected trigger edge for edge-started modes
	function automatic logic edge_hit(input logic [4:0] m,
		input logic rise, input logic fall);
		if (m == MODE_EDGE_LIMIT_RISE || m == MODE_MONO_RISE)
			return rise;
		else if (m == MODE_EDGE_LIMIT_FALL || m == MODE_MONO_FALL)
			return fall;
		else
			return rise | fall;
	endfunction

	// high-level variants hold reset while the signal is high
	function automatic logic at_reset(input logic [4:0] m,
		input logic lvl);
		if (m == MODE_LVLRST_HIGH || m == MODE_LVLTRIG_HIGH)
			return lvl;
		else
			return ~lvl;
	endfunction

endpackage

// file: rtl/thl_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module thl_sync
	import thl_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level  <= '0;
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			// a change counts only once stages two and three agree
			level  <= (stage2 & stage3) | (level & (stage2 ^ stage3));
		end
	end
endmodule

// file: rtl/thl_prescaler.sv
// power-of-two prescaler on timer clock events
`timescale 1ns/1ns
module thl_prescaler
	import thl_pkg::*;
#(
	parameter int W = 7
)(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       clear,
	input  wire logic       event_in,
	input  wire logic [2:0] select,
	output logic            tick
);
	logic [W-1:0] cnt;
	logic [W:0]   limit_wide;
	logic [W-1:0] limit;

	assign limit_wide = ((W+1)'(1) << select) - (W+1)'(1);
	assign limit      = limit_wide[W-1:0];
	assign tick       = event_in & (cnt == limit);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= '0;
		else if (clear)
			cnt <= '0;
		else if (event_in)
			cnt <= tick ? '0 : cnt + W'(1);
	end

	a_prescale_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		(tick && !clear) |=> (cnt == '0))
		else $error("prescaler did not wrap after tick");
endmodule

// file: rtl/thl_timer.sv
// 8-bit period timer with hardware-limit and one-shot modes, APB slave
`timescale 1ns/1ns
module thl_timer
	import thl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	input  wire logic        ext_clock_pin,
	input  wire logic        fast_internal_osc,
	input  wire logic        slow_internal_osc,
	input  wire logic        medium_osc_500k,
	input  wire logic        medium_osc_31k,
	input  wire logic [6:0]  internal_sources,
	input  wire logic        external_reset_signal,
	output logic             pwm_out,
	output logic             period_match,
	output logic             timer_flag,
	output logic [2:0]       osc_keep_running
);
	// ****************************************
	// registers
	// ****************************************
	logic [3:0] clock_select;
	logic       on_bit;
	logic [2:0] prescale_select;
	logic [3:0] postscale_select;
	logic       prescaler_sync_enable;
	logic [4:0] mode;
	logic [7:0] period_value;
	logic [7:0] pulse_width_value;
	logic [7:0] timer_count;
	logic       flag;

	thl_state_e state;
	thl_state_e next_state;
	logic [7:0] next_count;
	logic       next_pwm;
	logic [1:0] hold_cnt;
	logic [1:0] next_hold;
	logic       clear_on;
	logic       do_step;
	logic       match_clears_on;
	logic       period_hit;
	logic [3:0] post_cnt;
	logic [1:0] quarter;

	logic       wr_access;
	logic       wr_control;
	logic       rd_setup;
	logic       mapped;

	logic [SYNC_SOURCES-1:0] src_level;
	logic [SYNC_SOURCES-1:0] src_prev;
	logic [SYNC_SOURCES-1:0] src_rise;
	logic       src_event;
	logic       src_gated;
	logic       tick;
	logic       ers_prev;
	logic       ers_rise;
	logic       ers_fall;
	logic       trig;
	logic       atr;
	logic       leave_reset;
	logic       match;
	logic       pw_match;
	thl_class_e cls;

	// ****************************************
	// APB slave
	// ****************************************
	function automatic logic addr_mapped(input logic [7:0] a);
		if (a == ADDR_CLOCK_SELECT || a == ADDR_CONTROL)
			return 1'b1;
		else if (a == ADDR_LIMIT || a == ADDR_PERIOD)
			return 1'b1;
		else if (a == ADDR_PULSE_WIDTH || a == ADDR_COUNT)
			return 1'b1;
		else
			return a == ADDR_STATUS;
	endfunction

	assign pready     = 1'b1;
	assign mapped     = addr_mapped(paddr);
	assign pslverr    = psel & penable & ~mapped;
	assign wr_access  = psel & penable & pwrite & mapped;
	assign wr_control = wr_access & (paddr == ADDR_CONTROL);
	assign rd_setup   = psel & ~penable & ~pwrite;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clock_select          <= RESET_CLOCK_SELECT;
			prescale_select       <= RESET_CONTROL[6:4];
			postscale_select      <= RESET_CONTROL[3:0];
			prescaler_sync_enable <= RESET_LIMIT[LIMIT_SYNC_BIT];
			mode                  <= RESET_LIMIT[4:0];
			period_value          <= RESET_PERIOD;
			pulse_width_value     <= RESET_PULSE_WIDTH;
		end
		else if (wr_access)
		begin
			if (paddr == ADDR_CLOCK_SELECT)
				clock_select <= pwdata[3:0];
			else if (paddr == ADDR_CONTROL)
			begin
				prescale_select  <= pwdata[CTRL_PRESCALE_LSB +: 3];
				postscale_select <= pwdata[CTRL_POSTSCALE_LSB +: 4];
			end
			else if (paddr == ADDR_LIMIT)
			begin
				prescaler_sync_enable <= pwdata[LIMIT_SYNC_BIT];
				mode <= pwdata[LIMIT_MODE_LSB +: 5];
			end
			else if (paddr == ADDR_PERIOD)
				period_value <= pwdata[7:0];
			else if (paddr == ADDR_PULSE_WIDTH)
				pulse_width_value <= pwdata[7:0];
		end
	end

	// software write beats a hardware clear in the same cycle
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			on_bit <= RESET_CONTROL[CTRL_ON_BIT];
		else if (wr_control)
			on_bit <= pwdata[CTRL_ON_BIT];
		else if (clear_on)
			on_bit <= 1'b0;
	end

	// read data is captured in the setup cycle
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			prdata <= '0;
		else if (rd_setup)
		begin
			if (paddr == ADDR_CLOCK_SELECT)
				prdata <= {28'h0, clock_select};
			else if (paddr == ADDR_CONTROL)
				prdata <= {24'h0, on_bit, prescale_select, postscale_select};
			else if (paddr == ADDR_LIMIT)
				prdata <= {24'h0, prescaler_sync_enable, 2'h0, mode};
			else if (paddr == ADDR_PERIOD)
				prdata <= {24'h0, period_value};
			else if (paddr == ADDR_PULSE_WIDTH)
				prdata <= {24'h0, pulse_width_value};
			else if (paddr == ADDR_COUNT)
				prdata <= {24'h0, timer_count};
			else if (paddr == ADDR_STATUS)
				prdata <= {31'h0, flag};
			else
				prdata <= '0;
		end
	end

	// ****************************************
	// timer clock selection
	// ****************************************
	thl_sync #(
		.W (SYNC_SOURCES)
	) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in ({internal_sources, medium_osc_31k, medium_osc_500k,
			slow_internal_osc, fast_internal_osc, ext_clock_pin}),
		.level    (src_level)
	);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			src_prev <= '0;
			quarter  <= '0;
		end
		else
		begin
			src_prev <= src_level;
			quarter  <= quarter + 2'h1;
		end
	end

	assign src_rise = src_level & ~src_prev;

	always_comb
	begin
		src_event = 1'b0;
		case (clock_select)
			CS_PIN:      src_event = src_rise[0];
			CS_FOSC4:    src_event = (quarter == FOSC4_LAST);
			CS_FOSC:     src_event = 1'b1;
			CS_FAST:     src_event = src_rise[1];
			CS_SLOW:     src_event = src_rise[2];
			CS_MED_500K: src_event = src_rise[3];
			CS_MED_31K:  src_event = src_rise[4];
			CS_RSVD_LO:  src_event = 1'b0;
			default:
				if (clock_select <= CS_LOGIC_HI)
					src_event = src_rise[clock_select - CS_TO_INDEX];
		endcase
	end

	// with sync on, timer clock events are blocked while asleep
	assign src_gated = src_event & on_bit
		& ~(prescaler_sync_enable & sleep_mode);

	thl_prescaler #(
		.W (7)
	) u_prescaler (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.clear    (~on_bit),
		.event_in (src_gated),
		.select   (prescale_select),
		.tick     (tick)
	);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			osc_keep_running <= '0;
		else
		begin
			osc_keep_running[0] <= sleep_mode
				& (clock_select == CS_FAST);
			osc_keep_running[1] <= sleep_mode & (clock_select == CS_SLOW);
			osc_keep_running[2] <= sleep_mode
				& (clock_select == CS_MED_500K
				|| clock_select == CS_MED_31K);
		end
	end

	// ****************************************
	// mode control
	// ****************************************
	// the reset signal comes from logic on this clock
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			ers_prev <= 1'b0;
		else
			ers_prev <= external_reset_signal;
	end

	assign ers_rise    = external_reset_signal & ~ers_prev;
	assign ers_fall    = ~external_reset_signal & ers_prev;
	assign cls         = mode_class(mode);
	assign trig        = edge_hit(mode, ers_rise, ers_fall);
	assign atr         = at_reset(mode, external_reset_signal);
	assign leave_reset = at_reset(mode, ers_prev) & ~atr;
	assign match       = (timer_count == period_value);
	assign pw_match    = (timer_count == pulse_width_value);
	assign period_hit  = do_step & tick & match;

	always_comb
	begin
		next_state      = state;
		next_count      = timer_count;
		next_pwm        = pwm_out;
		next_hold       = hold_cnt;
		do_step         = 1'b0;
		match_clears_on = 1'b1;
		if (!on_bit)
		begin
			next_state = ST_IDLE;
			next_count = '0;
			next_pwm   = 1'b0;
			next_hold  = '0;
		end
		else
		begin
			case (cls)
				CL_EDGE_LIMIT:
					if (trig)
					begin
						next_count = '0;
						next_pwm   = 1'b1;
						if (state == ST_IDLE)
							next_state = ST_RUN;
						else
						begin
							next_state = ST_HOLD;
							next_hold  = RESTART_TICKS;
						end
					end
					else if (state == ST_HOLD && tick)
					begin
						next_hold = hold_cnt - 2'h1;
						if (hold_cnt == 2'h1)
							next_state = ST_RUN;
					end
					else
						do_step = (state == ST_RUN);
				CL_LVLRST:
					if (atr)
					begin
						next_count = '0;
						next_state = ST_IDLE;
					end
					else if (state == ST_IDLE && leave_reset)
					begin
						next_state = ST_RUN;
						next_pwm   = 1'b1;
					end
					else
						do_step = (state == ST_RUN);
				CL_MONO:
				begin
					match_clears_on = 1'b0;
					if (state == ST_IDLE && trig)
					begin
						next_state = ST_RUN;
						next_pwm   = 1'b1;
					end
					else
						do_step = (state == ST_RUN);
				end
				CL_LVLTRIG:
					if (atr)
					begin
						next_count = '0;
						next_state = ST_IDLE;
					end
					else if (state == ST_IDLE)
					begin
						next_state = ST_RUN;
						next_pwm   = 1'b1;
					end
					else
						do_step = 1'b1;
				default:
				begin
					match_clears_on = 1'b0;
					next_state      = ST_RUN;
					do_step         = 1'b1;
				end
			endcase
			if (do_step && tick)
			begin
				if (pw_match)
					next_pwm = 1'b0;
				if (match)
				begin
					next_count = '0;
					if (cls != CL_OTHER)
						next_state = ST_IDLE;
					if (cls == CL_OTHER)
						next_pwm = 1'b1;
				end
				else
					next_count = timer_count + 8'h01;
			end
		end
	end

	assign clear_on = period_hit & match_clears_on;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state       <= ST_IDLE;
			timer_count <= '0;
			pwm_out     <= 1'b0;
			hold_cnt    <= '0;
		end
		else
		begin
			state       <= next_state;
			timer_count <= next_count;
			pwm_out     <= next_pwm;
			hold_cnt    <= next_hold;
		end
	end

	// ****************************************
	// postscaler and flag
	// ****************************************
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			post_cnt     <= '0;
			period_match <= 1'b0;
		end
		else
		begin
			period_match <= period_hit;
			if (!on_bit)
				post_cnt <= '0;
			else if (period_hit)
				post_cnt <= (post_cnt == postscale_select)
					? 4'h0 : post_cnt + 4'h1;
		end
	end

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			flag <= 1'b0;
		else if (period_hit && post_cnt == postscale_select)
			flag <= 1'b1;
		else if (wr_access && paddr == ADDR_STATUS
			&& pwdata[STATUS_FLAG_BIT])
			flag <= 1'b0;
	end

	assign timer_flag = flag;

	// ****************************************
	// checks
	// ****************************************
	a_on_hw_clear: assert property (@(posedge clock) disable iff (sys_rst)
		(clear_on && !wr_control) |=> !on_bit)
		else $error("on bit not cleared after limit match");
	a_off_resets: assert property (@(posedge clock) disable iff (sys_rst)
		!on_bit |=> (timer_count == 8'h00 && state == ST_IDLE && !pwm_out))
		else $error("counting state not reset while off");
	a_restart_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(on_bit && cls == CL_EDGE_LIMIT && state == ST_RUN && trig)
		|=> (state == ST_HOLD && hold_cnt == 2'h2 && timer_count == 8'h00))
		else $error("reset edge did not enter two-tick hold");
	a_edge_start: assert property (@(posedge clock) disable iff (sys_rst)
		(on_bit && cls == CL_EDGE_LIMIT && state == ST_IDLE && trig)
		|=> (state == ST_RUN && pwm_out))
		else $error("edge did not start the timer and pulse");
	a_level_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(on_bit && cls == CL_LVLRST && atr) |=> timer_count == 8'h00)
		else $error("count not held at reset level");
	a_mono_keep_on: assert property (@(posedge clock) disable iff (sys_rst)
		(cls == CL_MONO && period_hit && !wr_control)
		|=> (on_bit && state == ST_IDLE))
		else $error("monostable match mishandled");
	a_lvtrig_start: assert property (@(posedge clock) disable iff (sys_rst)
		(on_bit && cls == CL_LVLTRIG && !atr && state == ST_IDLE)
		|=> (state == ST_RUN && pwm_out))
		else $error("level-triggered start missed");
	a_sleep_freeze: assert property (@(posedge clock) disable iff (sys_rst)
		(prescaler_sync_enable && sleep_mode && on_bit
		&& (cls == CL_MONO || cls == CL_OTHER))
		|=> $stable(timer_count))
		else $error("timer moved during sleep");
	a_period_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		period_hit |=> (timer_count == 8'h00 && period_match))
		else $error("count not cleared after period match");
	a_post_flag: assert property (@(posedge clock) disable iff (sys_rst)
		(period_hit && post_cnt == postscale_select) |=> flag)
		else $error("flag not raised at postscale count");
endmodule

// file: tb/thl_ccp_model.sv
// partner model: external reset source and pwm drive observer
`timescale 1ns/1ns
module thl_ccp_model
(
	input  wire logic   clock,
	input  wire logic   sys_rst,
	input  wire logic   ers_req,
	input  wire logic   pwm_out,
	output logic        external_reset_signal,
	output logic [15:0] pwm_cycles
);
	// ****************************************
	// reset source
	// ****************************************
	// same-clock logic: level only changes at a rising edge
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			external_reset_signal <= 1'b0;
		else
			external_reset_signal <= ers_req;

	// ****************************************
	// pwm observer
	// ****************************************
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			pwm_cycles <= 16'h0000;
		else if (pwm_out)
			pwm_cycles <= pwm_cycles + 16'h0001;
endmodule

// file: tb/testbench.sv
// self-checking bench for the hardware-limit timer
`timescale 1ns/1ns
module testbench
	import thl_pkg::*;
;
	logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        sleep_mode, ext_clock_pin, ers_req, ers, pwm_out;
	logic        period_match, timer_flag, rerr;
	logic [2:0]  osc_keep_running;
	logic [15:0] pwm_cycles, pwm_base;
	int          miscompares, num_checks;

	thl_timer i_dut (.clock(clock), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_mode(sleep_mode), .ext_clock_pin(ext_clock_pin),
		.fast_internal_osc(1'b0), .slow_internal_osc(1'b0),
		.medium_osc_500k(1'b0), .medium_osc_31k(1'b0),
		.internal_sources(7'h00), .external_reset_signal(ers),
		.pwm_out(pwm_out), .period_match(period_match),
		.timer_flag(timer_flag), .osc_keep_running(osc_keep_running));

	thl_ccp_model i_ccp (.clock(clock), .sys_rst(sys_rst),
		.ers_req(ers_req), .pwm_out(pwm_out),
		.external_reset_signal(ers), .pwm_cycles(pwm_cycles));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// apb master: enter just after a rising edge
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			miscompares++;
			wrap_up();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h00000000);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rd(ADDR_CLOCK_SELECT); chk(rdata, 32'(RESET_CLOCK_SELECT));
		rd(ADDR_CONTROL); chk(rdata, 32'(RESET_CONTROL));
		rd(ADDR_LIMIT); chk(rdata, 32'(RESET_LIMIT));
		rd(ADDR_PERIOD); chk(rdata, 32'(RESET_PERIOD));
		rd(ADDR_PULSE_WIDTH); chk(rdata, 32'(RESET_PULSE_WIDTH));
		rd(8'h1C); chk({rdata[30:0], rerr}, 32'h00000001);
		$display("regs done");
	endtask

	task automatic t_edge_limit();
		wr(ADDR_CLOCK_SELECT, 32'(CS_FOSC));
		wr(ADDR_LIMIT, 32'(MODE_EDGE_LIMIT_RISE));
		wr(ADDR_PERIOD, 32'h14);
		wr(ADDR_PULSE_WIDTH, 32'h02);
		ers_req <= 1'b1;
		cyc(4);
		ers_req <= 1'b0;
		cyc(3);
		wr(ADDR_CONTROL, 32'h80);
		cyc(6);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		wr(ADDR_COUNT, 32'h55);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		pwm_base = pwm_cycles;
		ers_req <= 1'b1;
		cyc(8);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] >= 8'h03), 32'h1);
		ers_req <= 1'b0;
		cyc(1);
		ers_req <= 1'b1;
		cyc(3);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] < 8'h03), 32'h1);
		cyc(40);
		rd(ADDR_CONTROL); chk(rdata, 32'h0);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		chk(32'(pwm_cycles - pwm_base >= 16'h4), 32'h1);
		chk(32'(pwm_cycles - pwm_base <= 16'hC), 32'h1);
		ers_req <= 1'b0;
		$display("edge limit done");
	endtask

	task automatic t_mono();
		wr(ADDR_LIMIT, 32'(MODE_MONO_RISE));
		wr(ADDR_PERIOD, 32'h05);
		wr(ADDR_CONTROL, 32'h80);
		ers_req <= 1'b1;
		cyc(4);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] != 8'h00), 32'h1);
		cyc(20);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		rd(ADDR_CONTROL); chk(rdata, 32'h80);
		wr(ADDR_CONTROL, 32'h00);
		ers_req <= 1'b0;
		$display("monostable done");
	endtask

	task automatic t_lvltrig();
		wr(ADDR_LIMIT, 32'(MODE_LVLTRIG_LOW));
		wr(ADDR_CONTROL, 32'h80);
		cyc(10);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		ers_req <= 1'b1;
		cyc(4);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] != 8'h00), 32'h1);
		cyc(20);
		rd(ADDR_CONTROL); chk(rdata, 32'h0);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		ers_req <= 1'b0;
		$display("level trigger done");
	endtask

	task automatic t_lvlrst();
		wr(ADDR_LIMIT, 32'(MODE_LVLRST_LOW));
		wr(ADDR_PERIOD, 32'h05);
		wr(ADDR_CONTROL, 32'h80);
		cyc(5);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		pwm_base = pwm_cycles;
		ers_req <= 1'b1;
		cyc(4);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] != 8'h00), 32'h1);
		cyc(20);
		rd(ADDR_CONTROL); chk(rdata, 32'h0);
		chk(32'(pwm_cycles - pwm_base), 32'h3);
		// signal already off the reset level: no edge, no restart
		wr(ADDR_CONTROL, 32'h80);
		cyc(10);
		rd(ADDR_CONTROL); chk(rdata, 32'h80);
		wr(ADDR_CONTROL, 32'h00);
		ers_req <= 1'b0;
		$display("level reset done");
	endtask

	task automatic t_scale();
		wr(ADDR_LIMIT, 32'h00);
		wr(ADDR_PERIOD, 32'hFF);
		wr(ADDR_CONTROL, 32'hB0);
		cyc(80);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] inside {[8:11]}), 32'h1);
		wr(ADDR_CONTROL, 32'h00);
		rd(ADDR_COUNT); chk(rdata, 32'h0);
		wr(ADDR_STATUS, 32'h01);
		wr(ADDR_PERIOD, 32'h03);
		wr(ADDR_CONTROL, 32'h81);
		cyc(5);
		chk(32'(timer_flag), 32'h0);
		cyc(20);
		chk(32'(timer_flag), 32'h1);
		wr(ADDR_CONTROL, 32'h00);
		$display("scalers done");
	endtask

	task automatic t_sleep();
		logic [31:0] held;
		wr(ADDR_LIMIT, 32'h80);
		wr(ADDR_PERIOD, 32'hFF);
		wr(ADDR_CONTROL, 32'h80);
		cyc(5);
		sleep_mode <= 1'b1;
		cyc(2);
		rd(ADDR_COUNT);
		held = rdata;
		cyc(10);
		rd(ADDR_COUNT); chk(rdata, held);
		rd(ADDR_PERIOD); chk(rdata, 32'hFF);
		wr(ADDR_LIMIT, 32'h00);
		rd(ADDR_COUNT); chk(32'(rdata != held), 32'h1);
		sleep_mode <= 1'b0;
		wr(ADDR_CONTROL, 32'h00);
		wr(ADDR_CLOCK_SELECT, 32'(CS_FAST));
		sleep_mode <= 1'b1;
		cyc(3);
		chk(32'(osc_keep_running), 32'h1);
		sleep_mode <= 1'b0;
		wr(ADDR_CLOCK_SELECT, 32'(CS_FOSC4));
		wr(ADDR_CONTROL, 32'h80);
		cyc(40);
		rd(ADDR_COUNT); chk(32'(rdata[7:0] inside {[9:11]}), 32'h1);
		wr(ADDR_CONTROL, 32'h00);
		$display("sleep done");
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		miscompares = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		ers_req = 1'b0;
		ext_clock_pin = 1'b0;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_regs();
		t_edge_limit();
		t_mono();
		t_lvltrig();
		t_lvlrst();
		t_scale();
		t_sleep();
		wrap_up();
	end

	// pin clock at half the system clock rate so the pin input is not a constant
	always @(posedge clock)
		ext_clock_pin <= ~ext_clock_pin;
endmodule
